/* File: design/sarcc_top.sv */
// Conversion control for the successive approximation converter:
// registers, start selection, burst sequencing, accumulation and window.
// Assumes timers pulse overflows on ref_clk; the start pin is asynchronous.
//
// Behaviour
// - Eight-bit select makes the converter resolve only the top eight bits.
// - Eight-bit conversion takes 11 SAR clocks, ten-bit takes 13.
// - In eight-bit mode low two bits are zero; low byte reads 0x00.
// - Twelve-bit sum needs burst with repeat code 001: four ten-bit passes at differing reference levels; accumulator bit 7 is unused.
// - Largest DAC elements are reassigned differently on each of four passes.
// - Twelve-bit sum lands in high and low result bytes; maximum 4092.
// - Repeat counts in multiples of four accumulate; sixteen gives 14-bit sum.
// - Power register bit 7 selects reduced converter and reference bias.
// - Control bit 7 enables converter; zero means low-power shutdown except while a burst (bit 6) start is running.
// - Control bit 6 selects burst operation.
// - Done flag bit 5 set per conversion or per burst; software clears.
// - Writing busy bit 4 starts conversion only with source 000.
// - Window flag bit 3 set when result falls inside window; software clears.
// - Start source: 000 software, 001/010/011 timers, 1xx external pin edge.
// - Busy reads 1 during conversion; its fall sets the done flag.
// - Burst start runs repeat count conversions; otherwise one per start.
// - Timer 2/3 use low-byte overflow in 8-bit mode, high-byte in 16-bit.
`timescale 1ns/1ps
`include "sarcc_regs.svh"

module sarcc_top
   import sarcc_pkg::*;
#(
   parameter int RES = 10
) (
   // Clock and reset
   input  wire logic           ref_clk,
   input  wire logic           resetn,
   // Register port
   input  wire logic [7:0]     sfr_addr,
   input  wire logic           sfr_wr,
   input  wire logic           sfr_rd,
   input  wire logic [7:0]     sfr_wdata,
   output logic [7:0]          sfr_rdata_q,
   // Start sources
   input  wire logic           timer0_ovf,
   input  wire logic           timer2_low_ovf,
   input  wire logic           timer2_high_ovf,
   input  wire logic           timer2_split,
   input  wire logic           timer3_low_ovf,
   input  wire logic           timer3_high_ovf,
   input  wire logic           timer3_split,
   input  wire logic           external_start_pin,
   // Analog front end
   input  wire logic           cmp_in,
   output logic [RES-1:0]      dac_code_q,
   output logic                sample_q,
   output logic [1:0]          pass_index_q,
   output logic                analog_on_q,
   output logic                low_bias_select_q,
   // Status
   output logic                conversion_done_flag_q,
   output logic                window_match_flag_q
);

   sarcc_state_t state_q;
   logic [7:0]   ctl_q;
   logic [7:0]   cfg_q;
   logic [7:0]   acc_cfg_q;
   logic [7:0]   pwr_q;
   logic [15:0]  gt_q;
   logic [15:0]  lt_q;
   logic [15:0]  result_q;
   logic [15:0]  acc_q;
   logic [6:0]   pass_q;
   logic         eng_start_q;
   logic [2:0]   pin_sync_q;
   logic         pin_level_q;
   logic [RES-1:0] eng_result;
   logic         eng_done;

   // Register decode
   wire wr_ctl = sfr_wr & (sfr_addr == `SARCC_ADDR_CONTROL);
   wire wr_cfg = sfr_wr & (sfr_addr == `SARCC_ADDR_CONFIG);
   wire wr_acc = sfr_wr & (sfr_addr == `SARCC_ADDR_ACC_CFG);
   wire wr_pwr = sfr_wr & (sfr_addr == `SARCC_ADDR_POWER);
   wire wr_gtl = sfr_wr & (sfr_addr == `SARCC_ADDR_GT_LOW);
   wire wr_gth = sfr_wr & (sfr_addr == `SARCC_ADDR_GT_HIGH);
   wire wr_ltl = sfr_wr & (sfr_addr == `SARCC_ADDR_LT_LOW);
   wire wr_lth = sfr_wr & (sfr_addr == `SARCC_ADDR_LT_HIGH);

   // Control fields
   wire       enable    = ctl_q[`SARCC_CTL_ENABLE];
   wire       burst     = ctl_q[`SARCC_CTL_BURST];
   wire [2:0] src       = ctl_q[`SARCC_CTL_SRC_HI:`SARCC_CTL_SRC_LO];
   wire       eight_bit = cfg_q[`SARCC_CFG_EIGHT_BIT];
   wire       busy      = state_q == SARCC_RUN;

   // Start source selection
   wire pin_rise = pin_sync_q[1] & pin_sync_q[2] & ~pin_level_q;
   wire t2_ovf   = timer2_split ? timer2_low_ovf : timer2_high_ovf;
   wire t3_ovf   = timer3_split ? timer3_low_ovf : timer3_high_ovf;
   wire sw_start = wr_ctl & sfr_wdata[`SARCC_CTL_BUSY] &
                   (src == `SARCC_SRC_SOFTWARE);
   wire trigger  = src[2]                      ? pin_rise :
                   (src == `SARCC_SRC_TIMER0)   ? timer0_ovf :
                   (src == `SARCC_SRC_TIMER2)   ? t2_ovf :
                   (src == `SARCC_SRC_TIMER3)   ? t3_ovf : sw_start;
   wire launch   = trigger & ~busy & (enable | burst);

   // Repeat count decode
   wire [2:0] rep_code = acc_cfg_q[`SARCC_ACC_REP_HI:`SARCC_ACC_REP_LO];
   wire [6:0] rep_cnt  = (rep_code == `SARCC_REP_4)  ? `SARCC_CNT_4  :
                         (rep_code == `SARCC_REP_8)  ? `SARCC_CNT_8  :
                         (rep_code == `SARCC_REP_16) ? `SARCC_CNT_16 :
                         (rep_code == `SARCC_REP_32) ? `SARCC_CNT_32 :
                         (rep_code == `SARCC_REP_64) ? `SARCC_CNT_64 : `SARCC_CNT_1;
   wire [6:0] run_len  = burst ? rep_cnt : `SARCC_CNT_1;

   // Accumulation and end of sequence
   wire [15:0] acc_sum  = acc_q + {{(16-RES){1'b0}}, eng_result};
   wire        seq_end  = eng_done & ((pass_q + 7'h1) == run_len);
   wire        in_win   = (acc_sum > gt_q) & (acc_sum < lt_q);
   wire        done_set = seq_end;
   wire        win_set  = seq_end & in_win;

   // Read mux; unmapped addresses read zero
   wire [7:0] ctl_rd  = {ctl_q[7:5], busy, ctl_q[3:0]};
   wire [7:0] res_lo  = eight_bit ? `SARCC_RST_BYTE : result_q[7:0];
   wire [7:0] res_hi  = eight_bit ? result_q[RES-1:RES-8] : result_q[15:8];
   wire [7:0] rd_mux  =
      (sfr_addr == `SARCC_ADDR_CONTROL)  ? ctl_rd    :
      (sfr_addr == `SARCC_ADDR_CONFIG)   ? cfg_q     :
      (sfr_addr == `SARCC_ADDR_ACC_CFG)  ? acc_cfg_q :
      (sfr_addr == `SARCC_ADDR_POWER)    ? pwr_q     :
      (sfr_addr == `SARCC_ADDR_RES_LOW)  ? res_lo    :
      (sfr_addr == `SARCC_ADDR_RES_HIGH) ? res_hi    :
      (sfr_addr == `SARCC_ADDR_GT_LOW)   ? gt_q[7:0] :
      (sfr_addr == `SARCC_ADDR_GT_HIGH)  ? gt_q[15:8] :
      (sfr_addr == `SARCC_ADDR_LT_LOW)   ? lt_q[7:0] :
      (sfr_addr == `SARCC_ADDR_LT_HIGH)  ? lt_q[15:8] : `SARCC_RST_BYTE;

   // Control register; hardware set wins over a software clear
   wire [7:0] ctl_wr = wr_ctl ? sfr_wdata : ctl_q;
   wire [7:0] ctl_d  = {ctl_wr[7:6],
                        ctl_wr[`SARCC_CTL_DONE] | done_set,
                        1'b0,
                        ctl_wr[`SARCC_CTL_WINDOW] | win_set,
                        ctl_wr[2:0]};

   // Register file
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         ctl_q       <= `SARCC_RST_CONTROL;
         cfg_q       <= `SARCC_RST_CONFIG;
         acc_cfg_q   <= `SARCC_RST_ACC_CFG;
         pwr_q       <= `SARCC_RST_POWER;
         gt_q        <= `SARCC_RST_WORD;
         lt_q        <= `SARCC_RST_WORD;
         sfr_rdata_q <= `SARCC_RST_BYTE;
      end else begin
         ctl_q       <= ctl_d;
         cfg_q       <= wr_cfg ? sfr_wdata : cfg_q;
         acc_cfg_q   <= wr_acc ? sfr_wdata : acc_cfg_q;
         pwr_q       <= wr_pwr ? sfr_wdata : pwr_q;
         gt_q        <= {wr_gth ? sfr_wdata : gt_q[15:8], wr_gtl ? sfr_wdata : gt_q[7:0]};
         lt_q        <= {wr_lth ? sfr_wdata : lt_q[15:8], wr_ltl ? sfr_wdata : lt_q[7:0]};
         sfr_rdata_q <= sfr_rd ? rd_mux : `SARCC_RST_BYTE;
      end
   end

   // External start pin synchroniser and settled level
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         pin_sync_q  <= 3'h0;
         pin_level_q <= 1'b0;
      end else begin
         pin_sync_q <= {pin_sync_q[1:0], external_start_pin};
         if (pin_sync_q[1] == pin_sync_q[2]) begin
            pin_level_q <= pin_sync_q[2];
         end
      end
   end

   // Conversion sequencer
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         state_q     <= SARCC_IDLE;
         eng_start_q <= 1'b0;
         pass_q      <= 7'h00;
         acc_q       <= `SARCC_RST_WORD;
         result_q    <= `SARCC_RST_WORD;
      end else begin
         eng_start_q <= 1'b0;
         unique case (state_q)
            SARCC_IDLE: begin
               if (launch) begin
                  state_q     <= SARCC_RUN;
                  eng_start_q <= 1'b1;
                  pass_q      <= 7'h00;
                  acc_q       <= `SARCC_RST_WORD;
               end
            end
            SARCC_RUN: begin
               if (eng_done) begin
                  acc_q  <= acc_sum;
                  pass_q <= pass_q + 7'h1;
                  if (seq_end) begin
                     state_q  <= SARCC_IDLE;
                     result_q <= acc_sum;
                  end else begin
                     eng_start_q <= 1'b1;
                  end
               end
            end
         endcase
      end
   end

   // Analog controls and status outputs
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         pass_index_q           <= 2'h0;
         analog_on_q            <= 1'b0;
         low_bias_select_q      <= 1'b0;
         conversion_done_flag_q <= 1'b0;
         window_match_flag_q    <= 1'b0;
      end else begin
         pass_index_q           <= pass_q[1:0];
         analog_on_q            <= enable | busy;
         low_bias_select_q      <= pwr_q[`SARCC_PWR_LOW_BIAS];
         conversion_done_flag_q <= ctl_q[`SARCC_CTL_DONE];
         window_match_flag_q    <= ctl_q[`SARCC_CTL_WINDOW];
      end
   end

   // Successive approximation engine
   sarcc_sar_engine #(
      .RES (RES)
   ) u_engine (
      .ref_clk    (ref_clk),
      .resetn     (resetn),
      .start      (eng_start_q),
      .eight_bit  (eight_bit),
      .cmp_in     (cmp_in),
      .dac_code_q (dac_code_q),
      .sample_q   (sample_q),
      .result_q   (eng_result),
      .done_q     (eng_done)
   );

endmodule // sarcc_top

/* File: shared/sarcc_regs.svh */
// Register map, field positions, reset values and timing counts of the
// converter control block. Included by every design file of the block.
`ifndef SARCC_REGS_SVH
`define SARCC_REGS_SVH

// Register addresses on the special function register port
`define SARCC_ADDR_CONTROL    8'he8
`define SARCC_ADDR_CONFIG     8'hbc
`define SARCC_ADDR_ACC_CFG    8'hba
`define SARCC_ADDR_POWER      8'hbb
`define SARCC_ADDR_RES_LOW    8'hbd
`define SARCC_ADDR_RES_HIGH   8'hbe
`define SARCC_ADDR_GT_LOW     8'hc3
`define SARCC_ADDR_GT_HIGH    8'hc4
`define SARCC_ADDR_LT_LOW     8'hc5
`define SARCC_ADDR_LT_HIGH    8'hc6

// Control register fields
`define SARCC_CTL_ENABLE      7
`define SARCC_CTL_BURST       6
`define SARCC_CTL_DONE        5
`define SARCC_CTL_BUSY        4
`define SARCC_CTL_WINDOW      3
`define SARCC_CTL_SRC_HI      2
`define SARCC_CTL_SRC_LO      0

// Other register fields
`define SARCC_CFG_EIGHT_BIT   2
`define SARCC_ACC_TWELVE_BIT  7
`define SARCC_ACC_REP_HI      2
`define SARCC_ACC_REP_LO      0
`define SARCC_PWR_LOW_BIAS    7

// Reset values
`define SARCC_RST_CONTROL     8'h00
`define SARCC_RST_CONFIG      8'hf8
`define SARCC_RST_ACC_CFG     8'h00
`define SARCC_RST_POWER       8'h00
`define SARCC_RST_WORD        16'h0000
`define SARCC_RST_BYTE        8'h00

// Start source codes
`define SARCC_SRC_SOFTWARE    3'h0
`define SARCC_SRC_TIMER0      3'h1
`define SARCC_SRC_TIMER2      3'h2
`define SARCC_SRC_TIMER3      3'h3

// Repeat count codes and counts
`define SARCC_REP_1           3'h0
`define SARCC_REP_4           3'h1
`define SARCC_REP_8           3'h2
`define SARCC_REP_16          3'h3
`define SARCC_REP_32          3'h4
`define SARCC_REP_64          3'h5
`define SARCC_CNT_1           7'h01
`define SARCC_CNT_4           7'h04
`define SARCC_CNT_8           7'h08
`define SARCC_CNT_16          7'h10
`define SARCC_CNT_32          7'h20
`define SARCC_CNT_64          7'h40

// Conversion length in SAR clocks
`define SARCC_CYC_8BIT        4'hb
`define SARCC_CYC_10BIT       4'hd

`endif

/* File: shared/sarcc_pkg.sv */
// Types shared by the converter control block.
// Assumes the register header is included by each design file.
package sarcc_pkg;

   // Sequencer states, Gray coded
   typedef enum logic [0:0] {
      SARCC_IDLE = 1'b0,
      SARCC_RUN  = 1'b1
   } sarcc_state_t;

endpackage

/* File: design/sarcc_sar_engine.sv */
// Bit-by-bit successive approximation engine for one conversion.
// Assumes the comparator input reflects the DAC code of the same cycle.
`timescale 1ns/1ps
`include "sarcc_regs.svh"

module sarcc_sar_engine
   import sarcc_pkg::*;
#(
   parameter int RES = 10
) (
   // Clock and reset
   input  wire logic           ref_clk,
   input  wire logic           resetn,
   // Control
   input  wire logic           start,
   input  wire logic           eight_bit,
   // Analog side
   input  wire logic           cmp_in,
   output logic [RES-1:0]      dac_code_q,
   output logic                sample_q,
   // Result
   output logic [RES-1:0]      result_q,
   output logic                done_q
);

   logic           active_q;
   logic [3:0]     cnt_q;
   logic [RES-1:0] mask_q;

   // Trial decode and eight-bit truncation
   wire [3:0]     last_cnt  = (eight_bit ? `SARCC_CYC_8BIT : `SARCC_CYC_10BIT) - 4'h1;
   wire           last      = cnt_q == last_cnt;
   wire [RES-1:0] msb       = {1'b1, {(RES-1){1'b0}}};
   wire [RES-1:0] drop_mask = eight_bit ? {{(RES-2){1'b0}}, 2'b11} : '0;
   wire [RES-1:0] mask_nx   = mask_q >> 1;
   wire [RES-1:0] code_kept = cmp_in ? dac_code_q : (dac_code_q & ~mask_q);

   // Conversion sequence
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         active_q   <= 1'b0;
         cnt_q      <= 4'h0;
         mask_q     <= '0;
         dac_code_q <= '0;
         result_q   <= '0;
         sample_q   <= 1'b0;
         done_q     <= 1'b0;
      end else begin
         sample_q <= start;
         done_q   <= active_q & last;
         if (start) begin
            active_q   <= 1'b1;
            cnt_q      <= 4'h0;
            mask_q     <= msb;
            dac_code_q <= msb;
         end else if (active_q) begin
            cnt_q      <= cnt_q + 4'h1;
            mask_q     <= mask_nx;
            dac_code_q <= code_kept | (mask_nx & ~drop_mask);
            if (last) begin
               active_q <= 1'b0;
               result_q <= code_kept & ~drop_mask;
            end
         end
      end
   end

endmodule // sarcc_sar_engine

/* File: verification/sarcc_cmp_model.sv */
// Comparator model standing at the analog side of the converter.
// Assumes the trial code settles within the cycle that drives it.
`timescale 1ns/1ps

module sarcc_cmp_model (
   // Input level and trial code
   input  wire logic [9:0] vin,
   input  wire logic [9:0] dac_code_q,
   // Decision
   output logic            cmp_in
);
   // High while the input reaches the trial level
   assign cmp_in = (vin >= dac_code_q);
endmodule // sarcc_cmp_model

/* File: verification/sarcc_assertions.sv */
// Port checker of the converter control block, bound to its top module.
// Assumes one-cycle register strobes on ref_clk.
`timescale 1ns/1ps
`include "sarcc_regs.svh"

module sarcc_assertions
   import sarcc_pkg::*;
#(
   parameter int RES = 10
) (
   // Clock and reset
   input wire logic           ref_clk,
   input wire logic           resetn,
   // Register port
   input wire logic [7:0]     sfr_addr,
   input wire logic           sfr_wr,
   input wire logic           sfr_rd,
   input wire logic [7:0]     sfr_wdata,
   input wire logic [7:0]     sfr_rdata_q,
   // Converter side
   input wire logic [RES-1:0] dac_code_q,
   input wire logic           sample_q,
   input wire logic [1:0]     pass_index_q,
   input wire logic           analog_on_q,
   input wire logic           low_bias_select_q,
   input wire logic           conversion_done_flag_q
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   logic eight_q;
   logic en_q;

   // Shadow copies of eight-bit select and enable
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         eight_q <= 1'b0;
         en_q    <= 1'b0;
      end else if (sfr_wr && sfr_addr == `SARCC_ADDR_CONFIG) begin
         eight_q <= sfr_wdata[`SARCC_CFG_EIGHT_BIT];
      end else if (sfr_wr && sfr_addr == `SARCC_ADDR_CONTROL) begin
         en_q <= sfr_wdata[`SARCC_CTL_ENABLE];
      end
   end

   a_low_byte_zero: assert property (
      sfr_rd && sfr_addr == `SARCC_ADDR_RES_LOW && eight_q |=> sfr_rdata_q == 8'h00)
      else $error("low byte not zero in eight-bit mode");
   a_first_trial_msb: assert property (
      sample_q |-> dac_code_q == {1'b1, {(RES-1){1'b0}}})
      else $error("first trial is not the top bit");
   a_pass_length: assert property (
      $rose(conversion_done_flag_q) |-> (eight_q ? $past(sample_q, 13) : $past(sample_q, 15)))
      else $error("done flag at wrong distance from pass start");
   a_sample_spacing: assert property (
      sample_q |=> !sample_q [*8])
      else $error("passes too close together");
   a_element_rotation: assert property (
      sample_q && $past(sample_q, 15) |-> pass_index_q == $past(pass_index_q, 15) + 2'h1)
      else $error("pass index did not advance");
   a_low_bias_mirror: assert property (
      sfr_wr && sfr_addr == `SARCC_ADDR_POWER |-> ##2 low_bias_select_q == $past(sfr_wdata[7], 2))
      else $error("low bias output does not follow power register");
   a_enable_powers: assert property (
      en_q |=> analog_on_q)
      else $error("converter off while enabled");
   a_done_held: assert property (
      $fell(conversion_done_flag_q) |-> $past(sfr_wr, 2) && !$past(sfr_wdata[5], 2)
         && $past(sfr_addr, 2) == `SARCC_ADDR_CONTROL)
      else $error("done flag dropped without software clear");
endmodule // sarcc_assertions

bind sarcc_top sarcc_assertions #(.RES(RES)) u_chk (
   .ref_clk(ref_clk), .resetn(resetn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
   .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata_q(sfr_rdata_q),
   .dac_code_q(dac_code_q), .sample_q(sample_q), .pass_index_q(pass_index_q),
   .analog_on_q(analog_on_q), .low_bias_select_q(low_bias_select_q),
   .conversion_done_flag_q(conversion_done_flag_q));

/* File: verification/testbench.sv */
// Self-checking bench of the converter control block.
// Assumes a 25 MHz clock and the comparator model at the analog side.
`timescale 1ns/1ps
`include "sarcc_regs.svh"

module testbench
   import sarcc_pkg::*;
;
   logic        ref_clk, resetn, sfr_wr, sfr_rd, cmp_in, sample_q;
   logic        analog_on_q, low_bias_q, done_q, win_q, e8;
   logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata_q, d;
   logic [9:0]  vin, dac_code_q;
   logic [5:0]  trig, t;
   logic [1:0]  split, pass_index_q;
   logic [15:0] res, gt, lt, e;
   logic [15:0] rst_tab [5] = '{16'he800, 16'hbcf8, 16'hba00, 16'hbb00, 16'h1200};
   int          failures, total_checks, n, n10, n8;

   // Clock
   initial ref_clk = 1'b0;
   always #20 ref_clk = ~ref_clk;

   sarcc_top uut (
      .ref_clk(ref_clk), .resetn(resetn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata_q(sfr_rdata_q),
      .timer0_ovf(trig[0]), .timer2_low_ovf(trig[1]), .timer2_high_ovf(trig[2]),
      .timer2_split(split[0]), .timer3_low_ovf(trig[3]), .timer3_high_ovf(trig[4]),
      .timer3_split(split[1]), .external_start_pin(trig[5]), .cmp_in(cmp_in),
      .dac_code_q(dac_code_q), .sample_q(sample_q), .pass_index_q(pass_index_q),
      .analog_on_q(analog_on_q), .low_bias_select_q(low_bias_q),
      .conversion_done_flag_q(done_q), .window_match_flag_q(win_q));
   sarcc_cmp_model u_cmp (.vin(vin), .dac_code_q(dac_code_q), .cmp_in(cmp_in));

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge ref_clk);
      sfr_addr = a;
      sfr_wdata = v;
      sfr_wr = 1'b1;
      @(negedge ref_clk);
      sfr_wr = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(negedge ref_clk);
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(negedge ref_clk);
      sfr_rd = 1'b0;
      v = sfr_rdata_q;
   endtask

   // Arm, trigger, wait for completion, then look at busy and done
   task automatic conv(input logic [7:0] c, input logic [5:0] tr, output int k);
      logic [7:0] s;
      wr(`SARCC_ADDR_CONTROL, c);
      repeat (2) @(negedge ref_clk);
      if (tr == 6'h00) begin
         wr(`SARCC_ADDR_CONTROL, c | 8'h10);
         rd(`SARCC_ADDR_CONTROL, s);
         chk(s[4], c[2:0] == 3'h0);
      end else begin
         // Pin level must stand long enough for two settled samples
         trig = tr;
         repeat (tr[5] ? 3 : 1) @(negedge ref_clk);
         trig = 6'h00;
      end
      k = 0;
      while (done_q !== 1'b1 && k < 1200) begin
         @(negedge ref_clk);
         k++;
      end
      rd(`SARCC_ADDR_CONTROL, s);
      chk(s[5:4], {k < 1200, 1'b0});
   endtask

   function automatic logic [15:0] exp_res(input logic [9:0] v, input logic m, input int k);
      return m ? {v[9:2], 8'h00} : 16'(k) * {6'h00, v};
   endfunction

   // Window compares the converted level, not the byte view of the result
   function automatic logic exp_win(input logic [9:0] v, input logic m,
                                    input logic [15:0] g, input logic [15:0] l);
      logic [15:0] lvl;
      lvl = {6'h00, v[9:2], (m ? 2'b00 : v[1:0])};
      return (g < lvl) && (lvl < l);
   endfunction

   task automatic print_verdict();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // Watchdog, about six times the expected length of the run
   initial begin
      #1000000;
      failures++;
      print_verdict();
   end

   initial begin
      {resetn, sfr_wr, sfr_rd, sfr_addr, sfr_wdata, trig, split, vin} = '0;
      failures = 0;
      total_checks = 0;
      void'($urandom(85187));
      repeat (3) @(negedge ref_clk);
      resetn = 1'b1;
      // Reset values and an unmapped place
      foreach (rst_tab[i]) begin
         rd(rst_tab[i][15:8], d);
         chk(d, rst_tab[i][7:0]);
      end
      wr(`SARCC_ADDR_POWER, 8'h80);
      repeat (2) @(negedge ref_clk);
      chk(low_bias_q, 16'h1);
      wr(`SARCC_ADDR_POWER, 8'h00);
      // Single conversions, eight and ten bits, with window
      for (int i = 0; i < 6; i++) begin
         vin = (i == 0) ? 10'h3ff : 10'($urandom);
         e8 = i[0];
         gt = (i < 2) ? 16'h0000 : 16'($urandom_range(0, 1100));
         lt = (i < 2) ? 16'hffff : 16'($urandom_range(0, 1100));
         e = exp_res(vin, e8, 1);
         wr(`SARCC_ADDR_CONFIG, {5'h1f, e8, 2'h0});
         wr(`SARCC_ADDR_GT_HIGH, gt[15:8]);
         wr(`SARCC_ADDR_GT_LOW, gt[7:0]);
         wr(`SARCC_ADDR_LT_HIGH, lt[15:8]);
         wr(`SARCC_ADDR_LT_LOW, lt[7:0]);
         conv(8'h80, 6'h00, n);
         rd(`SARCC_ADDR_RES_HIGH, res[15:8]);
         rd(`SARCC_ADDR_RES_LOW, res[7:0]);
         chk(res, e);
         chk(win_q, exp_win(vin, e8, gt, lt));
         if (e8) n8 = n;
         else n10 = n;
      end
      chk(16'(n10 - n8), 16'h2);
      // Twelve-bit sum at full scale, then sixteen passes
      wr(`SARCC_ADDR_CONFIG, 8'hf8);
      for (int i = 0; i < 2; i++) begin
         vin = (i == 0) ? 10'h3ff : 10'($urandom);
         wr(`SARCC_ADDR_ACC_CFG, i ? 8'h83 : 8'h81);
         conv(i ? 8'h40 : 8'hc0, 6'h00, n);
         rd(`SARCC_ADDR_RES_HIGH, res[15:8]);
         rd(`SARCC_ADDR_RES_LOW, res[7:0]);
         chk(res, exp_res(vin, 1'b0, i ? 16 : 4));
      end
      wr(`SARCC_ADDR_ACC_CFG, 8'h00);
      // Every hardware start source, timer byte picked by split mode
      for (int s = 1; s < 8; s++) begin
         split = 2'($urandom);
         t = (s == 1) ? 6'h01 : (s == 2) ? (split[0] ? 6'h02 : 6'h04) :
             (s == 3) ? (split[1] ? 6'h08 : 6'h10) : 6'h20;
         conv(8'h80 | 8'(s), t, n);
         chk(16'(n < 1200), 16'h1);
      end
      // Refused starts: wrong timer byte, disabled, busy write off source 000
      conv(8'h82, split[0] ? 6'h04 : 6'h02, n);
      chk(16'(n < 1200), 16'h0);
      conv(8'h01, 6'h01, n);
      chk(16'(n < 1200), 16'h0);
      conv(8'h81, 6'h00, n);
      chk(16'(n < 1200), 16'h0);
      print_verdict();
   end
endmodule // testbench
